// ### rtl/usp_pkg.sv
// Shared constants, phase type and decode functions of the serial port pair
package usp_pkg;
  localparam int CLK_NS     = 40;
  localparam int WR_NS      = 400;
  localparam int RD_NS      = 430;
  localparam int WR_CYC     = (WR_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC     = (RD_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_TCY    = 6;
  localparam int TX_READY_TCY   = 16;
  localparam int RX_READY_TCY   = 20;
  localparam int SYNC_MATCH_TCY = 25;
  localparam int TXIDLE_TCY = 16;
  localparam int CTRL_TCY   = 16;
  // Mode word fields
  localparam int MODE_BAUD_LSB = 0;
  localparam int MODE_LEN_LSB  = 2;
  localparam int MODE_ESD_BIT  = 6;
  localparam int MODE_SCS_BIT  = 7;
  // Command word fields
  localparam int CMD_TXEN_BIT = 0;
  localparam int CMD_DTR_BIT  = 1;
  localparam int CMD_RXE_BIT  = 2;
  localparam int CMD_ERST_BIT = 4;
  localparam int CMD_RTS_BIT  = 5;
  localparam int CMD_IRST_BIT = 6;
  localparam int CMD_HUNT_BIT = 7;
  // Device status word fields
  localparam int ST_TX_READY = 0;
  localparam int ST_RX_READY = 1;
  localparam int ST_TXIDLE = 2;
  localparam int ST_OVR    = 4;
  localparam int ST_SYN    = 6;
  // Controller registers on APB
  localparam logic [7:0] REG_WRITE = 8'h00;
  localparam logic [7:0] REG_STAT  = 8'h04;
  localparam logic [7:0] REG_READ  = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam logic [7:0] REG_IRQ   = 8'h10;
  localparam logic [7:0] REG_MASK  = 8'h14;
  localparam int WR_CD_BIT = 8;
  localparam int RD_VALID  = 8;
  localparam int HS_BUSY   = 0;
  localparam int HS_FLAG0  = 1;
  localparam int HS_INIT   = 5;
  localparam int FL_TX_READY = 0;
  localparam int IRQ_DONE  = 3;
  localparam int IRQ_W     = 4;

  typedef enum logic [1:0] {PH_MODE, PH_SYNC_FIRST, PH_SYNC_SECOND, PH_CMD} usp_phase_t;

  function automatic usp_phase_t usp_next_phase(input usp_phase_t ph, input logic [7:0] mode,
                                               input logic [7:0] b);
    usp_phase_t n;
    n = ph;
    case (ph)
      PH_MODE:        n = (b[MODE_BAUD_LSB +: 2] == 2'b00) ? PH_SYNC_FIRST : PH_CMD;
      PH_SYNC_FIRST:  n = mode[MODE_SCS_BIT] ? PH_CMD : PH_SYNC_SECOND;
      PH_SYNC_SECOND: n = PH_CMD;
      default:  n = b[CMD_IRST_BIT] ? PH_MODE : PH_CMD;
    endcase
    return n;
  endfunction

  function automatic logic usp_is_sync(input logic [7:0] mode);
    return mode[MODE_BAUD_LSB +: 2] == 2'b00;
  endfunction

  function automatic logic [3:0] usp_len(input logic [7:0] mode);
    return 4'h5 + {2'b00, mode[MODE_LEN_LSB +: 2]};
  endfunction

  function automatic logic [5:0] usp_fmax(input logic [7:0] mode);
    logic [5:0] f;
    f = 6'h00;
    case (mode[MODE_BAUD_LSB +: 2])
      2'b10:   f = 6'h0F;
      2'b11:   f = 6'h3F;
      default: f = 6'h00;
    endcase
    return f;
  endfunction
endpackage

// ### rtl/usp_if.sv
// Processor-side pins between the serial port and its bus controller
`timescale 1ns/1ps
interface usp_if;
  logic       cd;
  logic       wr_n;
  logic       rd_n;
  logic [7:0] hdata;
  logic       hdata_oe;
  logic [7:0] ddata;
  logic       ddata_oe;
  logic [7:0] dbus;
  logic       transmit_ready_flag;
  logic       receive_ready_flag;
  logic       transmitter_idle_flag;
  logic       sync_match_indicator_o;
  logic       sync_match_indicator_oe;
  logic       sync_match_indicator;

  // Resolved levels of the shared data bus and the sync pin
  assign dbus = ddata_oe ? ddata : (hdata_oe ? hdata : 8'hFF);
  assign sync_match_indicator = sync_match_indicator_oe & sync_match_indicator_o;

  modport dev (
    input  cd, wr_n, rd_n, dbus,
    output ddata, ddata_oe, transmit_ready_flag, receive_ready_flag,
    output transmitter_idle_flag, sync_match_indicator_o, sync_match_indicator_oe
  );
  modport hst (
    output cd, wr_n, rd_n, hdata, hdata_oe,
    input  dbus, transmit_ready_flag, receive_ready_flag, transmitter_idle_flag,
    input  sync_match_indicator
  );
endinterface

// ### rtl/usp_dev.sv
// Serial transceiver: init sequencing, status flags, transmitter and receiver
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module usp_dev
  import usp_pkg::*;
(
  input  logic pclk,                    // System clock
  input  logic presetn,                 // Asynchronous reset, active low
  usp_if.dev   bus,                     // Processor-side pins
  input  logic transmit_bit_clock,      // Transmit bit clock, falling edge shifts
  input  logic receive_bit_clock,       // Receive bit clock, rising edge samples
  input  logic rxd,                     // Serial receive data
  output logic txd,                     // Serial transmit data
  output logic dtr_n,                   // Terminal ready, active low
  output logic rts_n,                   // Send request, active low
  output logic transmitter_enable_state_n // Transmitter enabled, active low
);

  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic [7:0] d1;
    logic [7:0] d2;
    logic       wr_p;
    logic       rd_p;
    logic       tclk_p;
    logic       rclk_p;
    usp_phase_t ph;
    logic [7:0] mode;
    logic [7:0] sc1;
    logic [7:0] sc2;
    logic       txen_n;
    logic       dtr_n;
    logic       rts_n;
    logic       rxen;
    logic       hunt;
    logic       hst;
    logic [7:0] tbuf;
    logic       tfull;
    logic [9:0] tsh;
    logic [3:0] tcnt;
    logic [5:0] tdiv;
    logic       tsel;
    logic       tfill;
    logic [7:0] rsh;
    logic [3:0] rcnt;
    logic [5:0] rdiv;
    logic       rbusy;
    logic [7:0] rdat;
    logic       rx_ready;
    logic       ovr;
    logic       syn;
    logic [7:0] dout;
    logic       doe;
    logic       txd;
    logic       tx_ready;
    logic       txidle;
    logic       soe;
  } usp_dev_t;

  usp_dev_t r;
  usp_dev_t n;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [7:0] st;
    logic [7:0] ch;
    logic [7:0] msk;
    logic [3:0] ln;
    logic [5:0] fm;
    logic       sy;
    logic       wrr;
    logic       rdf;
    logic       rdr;
    logic       txf;
    logic       rxr;
    logic       rb;
    logic       ld;
    logic       hit;
    st  = 8'h00;
    ch  = 8'h00;
    ln  = usp_len(r.mode);
    fm  = usp_fmax(r.mode);
    sy  = usp_is_sync(r.mode);
    msk = 8'hFF >> (4'h8 - ln);
    n   = r;
    // Two-flop synchronisers on every pin from outside this clock
    n.s1  = {rxd, receive_bit_clock, transmit_bit_clock, bus.cd, bus.rd_n, bus.wr_n};
    n.s2  = r.s1;
    n.d1  = bus.dbus;
    n.d2  = r.d1;
    wrr   = r.s2[0] & ~r.wr_p;
    rdf   = ~r.s2[1] & r.rd_p;
    rdr   = r.s2[1] & ~r.rd_p;
    txf   = ~r.s2[3] & r.tclk_p;
    rxr   = r.s2[4] & ~r.rclk_p;
    rb    = r.s2[5];
    hit   = 1'b0;
    ld    = 1'b0;
    n.wr_p  = r.s2[0];
    n.rd_p  = r.s2[1];
    n.tclk_p = r.s2[3];
    n.rclk_p = r.s2[4];

    // Status word mirrors the flag pins bit for bit
    st[ST_TX_READY] = r.tx_ready;
    st[ST_RX_READY] = r.rx_ready;
    st[ST_TXIDLE] = r.txidle;
    st[ST_OVR]    = r.ovr;
    st[ST_SYN]    = r.syn;
    if (rdf) begin
      n.doe  = 1'b1;
      n.dout = r.s2[2] ? st : r.rdat;
      if (r.s2[2]) begin
        n.syn = 1'b0;
      end else begin
        n.rx_ready = 1'b0;
      end
    end
    if (rdr) begin
      n.doe = 1'b0;
    end

    // Transmitter, one bit per divided falling edge of the bit clock
    if (txf) begin
      if (r.tdiv != 6'h00) begin
        n.tdiv = r.tdiv - 6'h01;
      end else begin
        n.tdiv = fm;
        if (r.tcnt != 4'h0) begin
          n.txd  = r.tsh[0];
          n.tsh  = {1'b1, r.tsh[9:1]};
          n.tcnt = r.tcnt - 4'h1;
        end else begin
          ld = ~r.txen_n & (r.tfull | sy);
          ch = r.tfull ? r.tbuf : (r.tsel ? r.sc2 : r.sc1);
          ch = ch | ~msk;
          if (!ld) begin
            n.txd = 1'b1;
          end else begin
            n.tfull = 1'b0;
            n.tfill = ~r.tfull;
            // Idle filler alternates the two sync characters when both are used
            if (!r.tfull) begin
              n.tsel = ~r.tsel & ~r.mode[MODE_SCS_BIT];
            end
            if (sy) begin
              n.txd  = ch[0];
              n.tsh  = {3'b111, ch[7:1]};
              n.tcnt = ln - 4'h1;
            end else begin
              n.txd  = 1'b0;
              n.tsh  = {2'b11, ch};
              n.tcnt = ln + 4'h1;
            end
          end
        end
      end
    end

    // Processor writes: control words walk the init phases, data fills the buffer
    if (wrr) begin
      if (r.s2[2]) begin
        case (r.ph)
          PH_MODE:  n.mode = r.d2;
          PH_SYNC_FIRST:  n.sc1  = r.d2;
          PH_SYNC_SECOND: n.sc2  = r.d2;
          default: begin
            n.txen_n = ~r.d2[CMD_TXEN_BIT];
            n.dtr_n = ~r.d2[CMD_DTR_BIT];
            n.rts_n = ~r.d2[CMD_RTS_BIT];
            n.rxen  = r.d2[CMD_RXE_BIT];
            if (r.d2[CMD_HUNT_BIT]) begin
              n.hunt = 1'b1;
              n.hst  = 1'b0;
            end
            if (r.d2[CMD_ERST_BIT]) begin
              n.ovr = 1'b0;
            end
            if (r.d2[CMD_IRST_BIT]) begin
              n.txen_n = 1'b1;
              n.dtr_n = 1'b1;
              n.rts_n = 1'b1;
              n.rxen  = 1'b0;
            end
          end
        endcase
        n.ph = usp_next_phase(r.ph, (r.ph == PH_MODE) ? r.d2 : r.mode, r.d2);
      end else if (r.ph == PH_CMD) begin
        n.tbuf  = r.d2;
        n.tfull = 1'b1;
      end
    end

    // Receiver, sampling on rising edges of the bit clock
    if (rxr && r.rxen) begin
      if (sy) begin
        n.rsh = {rb, r.rsh[7:1]};
        ch    = n.rsh >> (4'h8 - ln);
        if (r.hunt) begin
          if (!r.hst) begin
            if (ch == (r.sc1 & msk)) begin
              hit    = r.mode[MODE_SCS_BIT];
              n.hst  = ~r.mode[MODE_SCS_BIT];
              n.rcnt = ln;
            end
          end else begin
            n.rcnt = r.rcnt - 4'h1;
            if (r.rcnt == 4'h1) begin
              hit   = (ch == (r.sc2 & msk));
              n.hst = 1'b0;
            end
          end
          if (hit) begin
            n.hunt = 1'b0;
            n.rcnt = ln;
            n.syn  = r.soe;
          end
        end else begin
          n.rcnt = r.rcnt - 4'h1;
          if (r.rcnt == 4'h1) begin
            n.rcnt  = ln;
            n.rdat     = ch;
            n.ovr      = n.ovr | n.rx_ready;
            n.rx_ready = 1'b1;
          end
        end
      end else if (!r.rbusy) begin
        // At 1x the detecting edge already sits on the start bit centre
        if (!rb) begin
          n.rbusy = 1'b1;
          n.rdiv  = fm >> 1;
          n.rcnt  = (fm == 6'h00) ? ln + 4'h1 : ln + 4'h2;
        end
      end else if (r.rdiv != 6'h00) begin
        n.rdiv = r.rdiv - 6'h01;
      end else begin
        n.rdiv = fm;
        n.rcnt = r.rcnt - 4'h1;
        if (r.rcnt == ln + 4'h2) begin
          n.rbusy = ~rb;
        end else if (r.rcnt == 4'h1) begin
          n.rbusy = 1'b0;
          n.rdat     = r.rsh >> (4'h8 - ln);
          n.ovr      = n.ovr | n.rx_ready;
          n.rx_ready = 1'b1;
        end else begin
          n.rsh = {rb, r.rsh[7:1]};
        end
      end
    end

    n.tx_ready = ~n.tfull & (n.ph == PH_CMD);
    n.txidle = ~n.tfull & ((n.tcnt == 4'h0) | n.tfill);
    n.soe    = usp_is_sync(n.mode) & ~n.mode[MODE_ESD_BIT];
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r        <= '0;
      r.s1     <= '1;
      r.s2     <= '1;
      r.wr_p   <= 1'b1;
      r.rd_p   <= 1'b1;
      // Edge history matches the synchroniser reset level, so no false edge
      r.tclk_p <= 1'b1;
      r.rclk_p <= 1'b1;
      r.ph     <= PH_MODE;
      r.txen_n <= 1'b1;
      r.dtr_n  <= 1'b1;
      r.rts_n  <= 1'b1;
      r.txd    <= 1'b1;
      r.txidle <= 1'b1;
    end else begin
      r <= n;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign bus.ddata                   = r.dout;
  assign bus.ddata_oe                = r.doe;
  assign bus.transmit_ready_flag     = r.tx_ready;
  assign bus.receive_ready_flag      = r.rx_ready;
  assign bus.transmitter_idle_flag   = r.txidle;
  assign bus.sync_match_indicator_o  = r.syn;
  assign bus.sync_match_indicator_oe = r.soe;
  assign txd                         = r.txd;
  assign dtr_n                       = r.dtr_n;
  assign rts_n                       = r.rts_n;
  assign transmitter_enable_state_n  = r.txen_n;
endmodule

// ### rtl/usp_host.sv
// Bus controller: APB registers turned into paced strobes toward the transceiver
`timescale 1ns/1ps
module usp_host
  import usp_pkg::*;
(
  input  logic        pclk,    // System clock
  input  logic        presetn, // Asynchronous reset, active low
  input  logic [7:0]  paddr,   // APB address
  input  logic        psel,    // APB select
  input  logic        penable, // APB enable
  input  logic        pwrite,  // APB direction
  input  logic [31:0] pwdata,  // APB write data
  output logic [31:0] prdata,  // APB read data
  output logic        pready,  // APB ready
  output logic        irq,     // Level interrupt
  usp_if.hst          bus      // Transceiver pins
);

  typedef enum logic [1:0] {H_IDLE, H_WR, H_RD, H_GAP} usp_hstate_t;

  typedef struct packed {
    logic [3:0]       fl1;
    logic [3:0]       fl2;
    logic [3:0]       fp;
    logic [7:0]       d1;
    logic [7:0]       d2;
    usp_phase_t       ph;
    logic [7:0]       mode;
    logic             pend;
    logic             pcd;
    logic [7:0]       pbyte;
    logic             rpend;
    logic             rcd;
    usp_hstate_t      st;
    logic [3:0]       cnt;
    logic [7:0]       rdat;
    logic             rvalid;
    logic [IRQ_W-1:0] ist;
    logic [IRQ_W-1:0] imask;
    logic             irq;
    logic             cd;
    logic             wr_n;
    logic             rd_n;
    logic [7:0]       hdata;
    logic             hoe;
    logic [31:0]      prdata;
    logic             pready;
  } usp_host_t;

  usp_host_t r;
  usp_host_t n;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [IRQ_W-1:0] clr;
    logic             done;
    clr  = '0;
    done = 1'b0;
    n    = r;
    n.fl1 = {bus.transmitter_idle_flag, bus.sync_match_indicator,
             bus.receive_ready_flag, bus.transmit_ready_flag};
    n.fl2 = r.fl1;
    n.fp  = r.fl2;
    n.d1  = bus.dbus;
    n.d2  = r.d1;

    case (r.st)
      H_IDLE: begin
        if (r.pend && (r.ph != PH_CMD || r.fl2[FL_TX_READY])) begin
          n.cd    = r.pcd;
          n.hdata = r.pbyte;
          n.hoe   = 1'b1;
          n.wr_n  = 1'b0;
          n.cnt   = 4'(WR_CYC - 1);
          n.st    = H_WR;
        end else if (r.rpend) begin
          n.cd   = r.rcd;
          n.rd_n = 1'b0;
          n.cnt  = 4'(RD_CYC - 1);
          n.st   = H_RD;
        end
      end
      H_WR: begin
        if (r.cnt != 4'h0) begin
          n.cnt = r.cnt - 4'h1;
        end else begin
          n.wr_n = 1'b1;
          n.pend = 1'b0;
          done   = 1'b1;
          if (r.cd) begin
            n.ph = usp_next_phase(r.ph, (r.ph == PH_MODE) ? r.hdata : r.mode, r.hdata);
            if (r.ph == PH_MODE) begin
              n.mode = r.hdata;
            end
          end
          n.cnt = 4'(GAP_TCY - 1);
          n.st  = H_GAP;
        end
      end
      H_RD: begin
        if (r.cnt != 4'h0) begin
          n.cnt = r.cnt - 4'h1;
        end else begin
          n.rd_n   = 1'b1;
          n.rdat   = r.d2;
          n.rvalid = 1'b1;
          n.rpend  = 1'b0;
          done     = 1'b1;
          n.cnt    = 4'(GAP_TCY - 1);
          n.st     = H_GAP;
        end
      end
      default: begin
        // Recovery gap; data stays driven as hold time after the strobe
        if (r.cnt != 4'h0) begin
          n.cnt = r.cnt - 4'h1;
        end else begin
          n.hoe = 1'b0;
          n.st  = H_IDLE;
        end
      end
    endcase

    //////////////////////////////////////////////////////////////////////////
    n.pready = psel & ~penable;
    if (psel && !penable) begin
      n.prdata = 32'h0000_0000;
      if (paddr == REG_STAT) begin
        n.prdata[HS_BUSY]         = r.pend | r.rpend | (r.st != H_IDLE);
        n.prdata[HS_FLAG0 +: 4]   = r.fl2;
        n.prdata[HS_INIT]         = (r.ph == PH_CMD);
      end else if (paddr == REG_RDATA) begin
        n.prdata[RD_VALID:0] = {r.rvalid, r.rdat};
      end else if (paddr == REG_IRQ) begin
        n.prdata[IRQ_W-1:0] = r.ist;
      end else if (paddr == REG_MASK) begin
        n.prdata[IRQ_W-1:0] = r.imask;
      end
    end
    if (psel && penable && r.pready && pwrite) begin
      if (paddr == REG_WRITE) begin
        if (!r.pend) begin
          n.pend  = 1'b1;
          n.pcd   = pwdata[WR_CD_BIT];
          n.pbyte = pwdata[7:0];
        end
      end else if (paddr == REG_READ) begin
        if (!r.rpend) begin
          n.rpend  = 1'b1;
          n.rcd    = pwdata[0];
          n.rvalid = 1'b0;
        end
      end else if (paddr == REG_IRQ) begin
        clr = pwdata[IRQ_W-1:0];
      end else if (paddr == REG_MASK) begin
        n.imask = pwdata[IRQ_W-1:0];
      end
    end
    // New events win over a clear in the same cycle
    n.ist = (r.ist & ~clr) | {done, r.fl2[2:0] & ~r.fp[2:0]};
    n.irq = |(n.ist & n.imask);
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r      <= '0;
      r.ph   <= PH_MODE;
      r.st   <= H_IDLE;
      r.wr_n <= 1'b1;
      r.rd_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign prdata       = r.prdata;
  assign pready       = r.pready;
  assign irq          = r.irq;
  assign bus.cd       = r.cd;
  assign bus.wr_n     = r.wr_n;
  assign bus.rd_n     = r.rd_n;
  assign bus.hdata    = r.hdata;
  assign bus.hdata_oe = r.hoe;
endmodule

// ### testbench/usp_monitor.sv
// Concurrent checks on the processor-side pins between controller and transceiver
`timescale 1ns/1ps
module usp_monitor (
  input logic pclk,                  // System clock
  input logic presetn,               // Asynchronous reset, active low
  input logic cd,                    // Control or data select
  input logic wr_n,                  // Write strobe
  input logic rd_n,                  // Read strobe
  input logic ddata_oe,              // Transceiver drives the bus
  input logic transmit_ready_flag,   // Transmit ready
  input logic receive_ready_flag,    // Receive ready
  input logic transmitter_idle_flag, // Transmitter idle
  input logic sync_match_indicator   // Resolved sync pin
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////
  a_write_gap: assert property ($rose(wr_n) |-> wr_n [*6])
    else $error("write strobes too close");
  a_data_ready: assert property ($fell(wr_n) && !cd |-> transmit_ready_flag)
    else $error("data write without transmit ready");
  a_data_clears: assert property ($rose(wr_n) && !cd && transmit_ready_flag |->
    ##[1:4] (!transmit_ready_flag && !transmitter_idle_flag))
    else $error("data write left ready or idle set");
  a_status_drive: assert property ($fell(rd_n) && cd |-> ##[2:4] ddata_oe)
    else $error("status read not driven");
  a_bus_float: assert property (rd_n && $past(rd_n, 4) |-> !ddata_oe)
    else $error("bus driven outside a read");
  a_no_clash: assert property (!wr_n |-> !ddata_oe)
    else $error("bus driven during a write");
  a_rx_clear: assert property ($rose(rd_n) && !cd |-> ##[0:6] !receive_ready_flag)
    else $error("data read left receive ready set");
  a_sync_clear: assert property ($rose(rd_n) && cd |-> ##[0:6] !sync_match_indicator)
    else $error("status read left sync match set");
endmodule

// ### testbench/tb.sv
// Self-checking bench for the transceiver and its bus controller, tied back to back
`timescale 1ns/1ps
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin fails++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, s); end end
module tb;
  import usp_pkg::*;
  typedef struct {logic cd; logic [7:0] b; logic [2:0] ctl;} usp_row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, irq, wr_q;
  logic        txd, dtr_n, rts_n, txen_n, tbc;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, st;
  logic [4:0]  fl;
  int          fails, compares, cyc, t_wr;
  int          bhalf = 160;
  usp_row_t    rows[5];
  usp_if       bus();
  assign fl = {irq, bus.sync_match_indicator, bus.transmitter_idle_flag,
               bus.receive_ready_flag, bus.transmit_ready_flag};
  usp_dev i_usp_dev (.pclk(pclk), .presetn(presetn), .bus(bus.dev), .transmit_bit_clock(tbc),
    .receive_bit_clock(tbc), .rxd(txd), .txd(txd), .dtr_n(dtr_n), .rts_n(rts_n),
    .transmitter_enable_state_n(txen_n));
  usp_host i_usp_host (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .irq(irq), .bus(bus.hst));
  usp_monitor i_usp_monitor (.pclk(pclk), .presetn(presetn), .cd(bus.cd), .wr_n(bus.wr_n),
    .rd_n(bus.rd_n), .ddata_oe(bus.ddata_oe), .transmit_ready_flag(bus.transmit_ready_flag),
    .receive_ready_flag(bus.receive_ready_flag),
    .transmitter_idle_flag(bus.transmitter_idle_flag),
    .sync_match_indicator(bus.sync_match_indicator));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    tbc = 1'b1;
    forever #(bhalf) tbc = ~tbc;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    wr_q <= bus.wr_n;
    if (bus.wr_n && !wr_q) begin
      t_wr <= cyc;
    end
    if (cyc == 60000) begin
      fails++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task hw(input logic c, input logic [7:0] b);
    logic [31:0] q;
    apb(1'b1, REG_WRITE, {23'h0, c, b}, q);
    do begin
      apb(1'b0, REG_STAT, 32'h0, q);
    end while (q[HS_BUSY] !== 1'b0);
  endtask
  task hr(input logic c, output logic [31:0] q);
    apb(1'b1, REG_READ, {31'h0, c}, q);
    do begin
      apb(1'b0, REG_RDATA, 32'h0, q);
    end while (q[RD_VALID] !== 1'b1);
  endtask
  task waitfl(input int k, input int lim);
    int n;
    n = 0;
    while (fl[k] !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task chk_init(input logic e);
    apb(1'b0, REG_STAT, 32'h0, st);
    `CHK("init done", e, st[HS_INIT])
  endtask
  task conclude;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    {cyc, fails, compares, t_wr} = '0;
    wr_q = 1'b1;
    rows = '{'{1'b1, 8'h0E, 3'h7}, '{1'b1, 8'h27, 3'h0}, '{1'b1, 8'h00, 3'h7},
             '{1'b1, 8'h02, 3'h5}, '{1'b1, 8'h25, 3'h2}};
    repeat (12) @(posedge pclk);
    `CHK("reset pins", 7'h7C, {txd, dtr_n, rts_n, txen_n, fl[2:0]})
    presetn <= 1'b1;
    chk_init(1'b0);
    foreach (rows[i]) begin
      hw(rows[i].cd, rows[i].b);
      while (cyc < t_wr + CTRL_TCY) @(posedge pclk);
      `CHK("control pins", rows[i].ctl, {txen_n, dtr_n, rts_n})
      if (i == 0) chk_init(1'b1);
    end
    // Data byte loops from the serial output back into the receiver
    hw(1'b0, 8'hA5);
    waitfl(1, 3000);
    `CHK("rx ready", 1'b1, fl[1])
    hr(1'b0, st);
    `CHK("rx byte", 8'hA5, st[7:0])
    waitfl(2, 3000);
    `CHK("tx idle", 1'b1, fl[2])
    hr(1'b1, st);
    `CHK("status", 3'h5, {st[ST_TXIDLE], st[ST_RX_READY], st[ST_TX_READY]})
    apb(1'b1, REG_IRQ, 32'hF, st);
    apb(1'b1, REG_MASK, 32'h1, st);
    `CHK("irq idle", 1'b0, irq)
    hw(1'b0, 8'h3C);
    waitfl(4, 3000);
    `CHK("irq set", 1'b1, irq)
    apb(1'b1, REG_IRQ, 32'h1, st);
    repeat (2) @(posedge pclk);
    `CHK("irq cleared", 1'b0, irq)
    apb(1'b0, 8'h20, 32'h0, st);
    `CHK("unmapped", 32'h0, st)
    apb(1'b1, REG_MASK, 32'h0, st);
    waitfl(2, 3000);
    `CHK("tx idle again", 1'b1, fl[2])
    // Back to the mode phase, then single-sync hunt on the looped filler
    hw(1'b1, 8'h40);
    bhalf = 640;
    hw(1'b1, 8'h8C);
    chk_init(1'b0);
    hw(1'b1, 8'h16);
    chk_init(1'b1);
    hw(1'b1, 8'hA5);
    waitfl(3, 3000);
    `CHK("sync match", 1'b1, fl[3])
    hr(1'b1, st);
    `CHK("status sync", 1'b1, st[ST_SYN])
    `CHK("sync cleared", 1'b0, fl[3])
    // Two sync characters must both be written before commands
    hw(1'b1, 8'h40);
    hw(1'b1, 8'h0C);
    hw(1'b1, 8'h16);
    chk_init(1'b0);
    hw(1'b1, 8'h16);
    chk_init(1'b1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK("reset again", 7'h7C, {txd, dtr_n, rts_n, txen_n, fl[2:0]})
    presetn <= 1'b1;
    conclude();
  end
endmodule
